// ---- measurement_trigger_control_tb.sv ----
// Testbench joining host and sensor ends through the link interface.
// Assumes measuring cycles shortened by TDIV so the run stays brief.
`timescale 1ns/1ps
module measurement_trigger_control_tb;
   import mtc_pkg::*;
   // Measuring cycles shortened to keep the run brief
   localparam int TDIV = 250;
   localparam int CYC = CYC_4K_CLKS / TDIV;
   logic clk = 1'b0;
   logic rst = 1'b1;
   mtc_rate_t rate = MTC_RATE_2K;
   logic rate_wr = 1'b0;
   logic factory = 1'b0;
   logic laser_set = 1'b0;
   logic laser_en_n = 1'b1;
   mtc_task_t task_sel = MTC_TASK_STD;
   mtc_trig_t mode = MTC_TRG_OFF;
   logic [13:0] count = 14'h0001;
   logic cmd_trig = 1'b0;
   logic cmd_stop = 1'b0;
   logic out_trig = 1'b0;
   logic pulse = 1'b0;
   logic level = 1'b0;
   mtc_fn_t din_fn = MTC_FN_OFF;
   logic [VAL_W-1:0] raw = 16'h0000;
   logic laser_on;
   logic valid;
   logic cycle;
   logic teach;
   logic busy;
   logic [VAL_W-1:0] data;
   logic [EXP_W-1:0] exp_max;
   logic [PRE_W-1:0] preset;
   mtc_rate_t rate_o;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;
   mtc_if lnk ();
   mtc_sensor #(.TIME_DIV(TDIV)) i_mtc_sensor (.i_clk(clk), .i_rst(rst), .lnk(lnk),
      .i_rate(rate), .i_rate_wr(rate_wr), .i_factory(factory), .i_save(1'b0),
      .i_din_fn(din_fn), .i_key_fn(MTC_FN_OFF), .i_key(1'b0), .i_master(16'h0000),
      .i_raw(raw), .i_laser_set(laser_set), .i_laser_en_n(laser_en_n), .i_task(task_sel),
      .o_laser_on(laser_on), .o_cycle(cycle), .o_exp_max(exp_max), .o_preset(preset),
      .o_teach(teach), .o_rate(rate_o));
   mtc_host #(.TIME_DIV(TDIV)) i_mtc_host (.i_clk(clk), .i_rst(rst), .lnk(lnk),
      .i_mode(mode), .i_count(count), .i_out_trig(out_trig), .i_pulse(pulse),
      .i_level(level), .i_cmd_trig(cmd_trig), .i_cmd_stop(cmd_stop), .o_busy(busy),
      .o_valid(valid), .o_data(data));
   mtc_checker #(.TIME_DIV(TDIV)) i_chk (.i_clk(clk), .i_rst(rst), .trig_pin(lnk.trig_pin),
      .cmd_trig(lnk.cmd_trig), .cmd_stop(lnk.cmd_stop), .cfg_count(lnk.cfg_count),
      .cfg_mode(lnk.cfg_mode), .cfg_out_trig(lnk.cfg_out_trig), .val_valid(lnk.val_valid),
      .val_data(lnk.val_data), .analog(lnk.analog));
   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      raw <= raw + 16'h0001;
      cycles++;
      if (cycles == 40_000) begin
         fail_count++;
         $display("CHECK FAILED at %0t: timeout", $time);
         finish_test;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic finish_test;
      $display("checks %0d, failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test
   task automatic wr_rate(input mtc_rate_t r);
      @(posedge clk);
      rate <= r;
      rate_wr <= 1'b1;
      @(posedge clk);
      rate_wr <= 1'b0;
      repeat (2) @(negedge clk);
   endtask : wr_rate
   task automatic count_valid(input int clks, output int n, output int first);
      n = 0;
      first = -1;
      for (int k = 0; k < clks; k++) begin
         @(negedge clk);
         if (valid === 1'b1) begin
            if (n == 0) first = k;
            n++;
         end
      end
   endtask : count_valid
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_rates;
      mtc_rate_t rates [5] = '{MTC_RATE_250, MTC_RATE_500, MTC_RATE_1K, MTC_RATE_2K,
         MTC_RATE_4K};
      logic [EXP_W-1:0] prev;
      for (int k = 0; k < 5; k++) begin
         prev = exp_max;
         wr_rate(rates[k]);
         check(rate_o === rates[k], "rate select");
         if (k > 0) check(exp_max < prev, "exposure limit order");
      end
      wr_rate(mtc_rate_t'(3'h7));
      check(rate_o === MTC_RATE_4K, "bad rate code taken");
      @(posedge clk);
      factory <= 1'b1;
      @(posedge clk);
      factory <= 1'b0;
      repeat (2) @(negedge clk);
      check(rate_o === MTC_RATE_2K, "factory rate");
      wr_rate(MTC_RATE_4K);
   endtask : t_rates
   task automatic t_laser_task;
      @(posedge clk);
      laser_set <= 1'b1;
      repeat (5) @(negedge clk);
      check(laser_on === 1'b0, "laser on without enable");
      @(posedge clk);
      laser_en_n <= 1'b0;
      repeat (5) @(negedge clk);
      check(laser_on === 1'b1, "laser setting ignored");
      @(posedge clk);
      laser_set <= 1'b0;
      repeat (2) @(negedge clk);
      check(laser_on === 1'b0, "laser off setting ignored");
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         task_sel <= mtc_task_t'(k);
         repeat (3) @(negedge clk);
         check(preset === (8'h01 << k), "task preset");
      end
   endtask : t_laser_task
   task automatic t_cont;
      int n = 0;
      int nc = 0;
      logic [VAL_W-1:0] last = '0;
      repeat (6 * CYC) @(posedge clk);
      for (int k = 0; k < 4 * CYC; k++) begin
         @(negedge clk);
         if (cycle === 1'b1) nc++;
         if (valid === 1'b1) begin
            if (n > 0) check(16'(data - last) === 16'(CYC), "value spacing");
            last = data;
            n++;
         end
      end
      check(n == 4, "continuous stream");
      check(nc == 4, "measuring cycles at top rate");
   endtask : t_cont
   task automatic t_cmd(input logic [13:0] cnt, input int exp_n, input logic otrig);
      int n;
      int first;
      @(posedge clk);
      mode <= MTC_TRG_CMD;
      count <= cnt;
      out_trig <= otrig;
      repeat (4 * CYC) @(posedge clk);
      cmd_trig <= 1'b1;
      @(posedge clk);
      cmd_trig <= 1'b0;
      count_valid(8 * CYC, n, first);
      check(n == exp_n, "burst length");
      if (exp_n > 0) check(first >= 3 * CYC - 2 && first <= 5 * CYC + 4, "latency");
   endtask : t_cmd
   task automatic t_stop;
      int n;
      int first;
      @(posedge clk);
      mode <= MTC_TRG_CMD;
      count <= CNT_ENDLESS;
      out_trig <= 1'b0;
      repeat (4 * CYC) @(posedge clk);
      cmd_trig <= 1'b1;
      @(posedge clk);
      cmd_trig <= 1'b0;
      count_valid(6 * CYC, n, first);
      check(n >= 2, "endless burst");
      @(posedge clk);
      cmd_stop <= 1'b1;
      @(posedge clk);
      cmd_stop <= 1'b0;
      count_valid(4 * CYC, n, first);
      check(n <= 3, "stop drains pipeline only");
      count_valid(4 * CYC, n, first);
      check(n == 0, "stop command");
   endtask : t_stop
   task automatic t_edge;
      int n;
      int first;
      @(posedge clk);
      mode <= MTC_TRG_RISE;
      count <= 14'h0003;
      din_fn <= MTC_FN_TRIG;
      repeat (4 * CYC) @(posedge clk);
      pulse <= 1'b1;
      @(posedge clk);
      pulse <= 1'b0;
      @(negedge clk);
      check(busy === 1'b1, "pulse hold");
      count_valid(8 * CYC, n, first);
      check(n == 3, "edge burst");
      check(busy === 1'b0, "pulse end");
   endtask : t_edge
   task automatic t_level;
      int n1;
      int n2;
      int first;
      @(posedge clk);
      mode <= MTC_TRG_LVL_HI;
      repeat (2 * CYC) @(posedge clk);
      level <= 1'b1;
      count_valid(3 * CYC, n1, first);
      @(posedge clk);
      level <= 1'b0;
      count_valid(7 * CYC, n2, first);
      check(n1 + n2 >= 3 && n1 + n2 <= 4, "level burst");
      count_valid(2 * CYC, n1, first);
      check(n1 == 0, "level stop");
   endtask : t_level
   task automatic t_teach;
      int n = 0;
      @(posedge clk);
      din_fn <= MTC_FN_TEACH;
      pulse <= 1'b1;
      @(posedge clk);
      pulse <= 1'b0;
      for (int k = 0; k < 4 * TRIG_MIN_CLKS / TDIV; k++) begin
         @(negedge clk);
         if (teach === 1'b1) n++;
      end
      check(n == 1, "teach pulse");
   endtask : t_teach
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check(rate_o === MTC_RATE_2K, "reset rate");
      t_rates;
      t_laser_task;
      t_cont;
      t_cmd(14'h0002, 2, 1'b0);
      t_cmd(14'h0002, 2, 1'b1);
      t_cmd(CNT_STOP, 0, 1'b0);
      t_stop;
      t_edge;
      t_level;
      t_teach;
      finish_test;
   end
endmodule : measurement_trigger_control_tb

// ---- mtc_checker.sv ----
// Checker for the trigger link between host and sensor ends.
// Assumes it sits beside the interface, on the one shared clock.
`timescale 1ns/1ps
module mtc_checker
   import mtc_pkg::*;
#(
   parameter int TIME_DIV = 1
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic trig_pin,
   input wire logic cmd_trig,
   input wire logic cmd_stop,
   input wire logic [13:0] cfg_count,
   input wire mtc_trig_t cfg_mode,
   input wire logic cfg_out_trig,
   input wire logic val_valid,
   input wire logic [VAL_W-1:0] val_data,
   input wire logic [VAL_W-1:0] analog
);
   localparam int SLOW_MAX = 5_100_000 / TIME_DIV;
   logic [31:0] gap_r;
   logic [31:0] idle_r;
   logic [31:0] low_r;
   logic [31:0] pend_r;
   logic [13:0] vcnt_r;
   logic armed_r;
   mtc_trig_t mode_r;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Helper counters
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         gap_r <= '1;
      end else if (val_valid) begin
         gap_r <= '0;
      end else if (gap_r != '1) begin
         gap_r <= gap_r + 32'h1;
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         idle_r <= '0;
         mode_r <= MTC_TRG_OFF;
      end else begin
         mode_r <= cfg_mode;
         idle_r <= (val_valid || cfg_mode != mode_r) ? 32'h0 : idle_r + 32'h1;
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         low_r <= '0;
      end else begin
         low_r <= (cfg_mode == MTC_TRG_LVL_HI && !trig_pin) ? low_r + 32'h1 : 32'h0;
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pend_r <= '0;
      end else if (val_valid || cmd_stop) begin
         pend_r <= '0;
      end else if (cmd_trig && cfg_mode == MTC_TRG_CMD && cfg_count != CNT_STOP) begin
         pend_r <= 32'h1;
      end else if (pend_r != '0) begin
         pend_r <= pend_r + 32'h1;
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         armed_r <= 1'b0;
         vcnt_r <= '0;
      end else if (cmd_trig && cfg_mode == MTC_TRG_CMD) begin
         armed_r <= 1'b1;
         vcnt_r <= '0;
      end else if (cfg_mode != MTC_TRG_CMD) begin
         armed_r <= 1'b0;
      end else if (val_valid && armed_r) begin
         vcnt_r <= vcnt_r + 14'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Properties
   property p_pulse;
      val_valid |=> !val_valid;
   endproperty
   a_pulse: assert property (p_pulse) else $error("valid longer than one clock");
   property p_hold;
      $changed(analog) |-> val_valid || $past(val_valid);
   endproperty
   a_hold: assert property (p_hold) else $error("analog changed without a value");
   property p_data;
      $changed(val_data) |-> val_valid || $past(val_valid);
   endproperty
   a_data: assert property (p_data) else $error("data changed without a value");
   property p_rate;
      val_valid |-> gap_r >= 32'(CYC_4K_CLKS / TIME_DIV - 1);
   endproperty
   a_rate: assert property (p_rate) else $error("values faster than top rate");
   property p_level;
      val_valid && cfg_mode == MTC_TRG_LVL_HI |-> low_r < SLOW_MAX;
   endproperty
   a_level: assert property (p_level) else $error("output without active level");
   property p_cont;
      cfg_mode == MTC_TRG_OFF |-> idle_r < SLOW_MAX;
   endproperty
   a_cont: assert property (p_cont) else $error("stream stalled untriggered");
   property p_lat;
      pend_r < SLOW_MAX;
   endproperty
   a_lat: assert property (p_lat) else $error("command trigger gave no output");
   property p_count;
      val_valid && armed_r && cfg_count != CNT_ENDLESS |-> vcnt_r < cfg_count;
   endproperty
   a_count: assert property (p_count) else $error("burst longer than count");
endmodule : mtc_checker

// ---- mtc_host.sv ----
// Host end: drives trigger pin pulses and commands toward the sensor.
// Assumes same clock as the sensor; user requests are single-cycle pulses.
`timescale 1ns/1ps
module mtc_host
   import mtc_pkg::*;
#(
   // Divides the pulse length; 1 gives the real timing
   parameter int TIME_DIV = 1
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   mtc_if.host lnk,
   input wire mtc_trig_t i_mode,
   input wire logic [13:0] i_count,
   input wire logic i_out_trig,
   input wire logic i_pulse,
   input wire logic i_level,
   input wire logic i_cmd_trig,
   input wire logic i_cmd_stop,
   output logic o_busy,
   output logic o_valid,
   output logic [VAL_W-1:0] o_data
);
   logic [15:0] hold_r;
   logic pin_r;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         hold_r <= 16'h0;
         pin_r <= 1'b0;
      end else if (hold_r != 16'h0) begin
         hold_r <= hold_r - 16'h1;
         if (hold_r == 16'h1) pin_r <= 1'b0;
      end else if (i_pulse) begin
         // Twice the least width keeps margin over the qualifier
         hold_r <= 16'(TRIG_MIN_CLKS * 2 / TIME_DIV);
         pin_r <= 1'b1;
      end
   end
   assign lnk.trig_pin = pin_r | i_level;
   assign o_busy = (hold_r != 16'h0);
   assign lnk.cmd_trig = i_cmd_trig;
   assign lnk.cmd_stop = i_cmd_stop;
   assign lnk.cfg_mode = i_mode;
   assign lnk.cfg_count = i_count;
   assign lnk.cfg_out_trig = i_out_trig;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_valid <= 1'b0;
         o_data <= '0;
      end else begin
         o_valid <= lnk.val_valid;
         if (lnk.val_valid) o_data <= lnk.val_data;
      end
   end
endmodule : mtc_host

// ---- mtc_if.sv ----
// Link between host controller and sensor trigger logic.
// Assumes both ends share i_clk; trigger pin is sampled by the sensor.
`timescale 1ns/1ps
interface mtc_if;
   import mtc_pkg::*;
   logic trig_pin;
   logic cmd_trig;
   logic cmd_stop;
   logic [13:0] cfg_count;
   mtc_trig_t cfg_mode;
   logic cfg_out_trig;
   logic val_valid;
   logic [VAL_W-1:0] val_data;
   logic [VAL_W-1:0] analog;
   modport sensor (input trig_pin, cmd_trig, cmd_stop, cfg_count, cfg_mode, cfg_out_trig,
      output val_valid, val_data, analog);
   modport host (output trig_pin, cmd_trig, cmd_stop, cfg_count, cfg_mode, cfg_out_trig,
      input val_valid, val_data, analog);
endinterface : mtc_if

// ---- mtc_pkg.sv ----
// Constants and types shared by both ends of the measurement trigger link.
// Assumes a single 250 MHz clock domain on each end; the link is plain wires.
//
// Overview of operation
// - Rates 250 Hz to 4 kHz selectable
// - Reset default rate is 2 kHz
// - Slower rate allows longer exposure limit
// - Output starts 3 cycles plus jitter after trigger
// - Trigger off: continuous output after start-up
// - Host holds trigger pulse at least 50 us
// - Modes: level, edge, command, inactive
// - Acquire or output trigger, same timing (here cfg_out_trig has no effect; both gate at acquisition)
// - Level mode outputs while level is active
// - Host holds level and pause one cycle
// - Edge count: 0 stop, 16383 endless
// - Command trigger uses same count rules
// - Host keeps trigger rate below measuring rate
// - Host should avoid data reduction when triggering
// - Digital input: trigger, zero, teach, inactive
// - Zeroing loads master value; teaching rescales
// - Key: zero, teach or locked
// - Laser setting valid only with enable grounded
// - Measurement task loads preset parameter set
// - Unsaved settings lost; saved restored at power-up (reset here loads RATE_RESET into both rate_r and saved_r; rate_r never loads from saved_r)
// - Cycle 250 us at 4 kHz, pipelined
// - Analog output holds last value after burst
package mtc_pkg;
   localparam int CLK_HZ = 250_000_000;
   localparam int CLK_NS = 4;
   // Cycle length at 4 kHz, in us
   localparam int CYC_4K_US = 250;
   localparam int CYC_4K_CLKS = (CYC_4K_US * 1000) / CLK_NS;
   // Least trigger pulse, in us, rounded up to clocks
   localparam int TRIG_MIN_US = 50;
   localparam int TRIG_MIN_CLKS = (TRIG_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int PIPE_CYCLES = 3;
   localparam int CNT_W = 14;
   localparam logic [13:0] CNT_ENDLESS = 14'h3fff;
   localparam logic [13:0] CNT_STOP = 14'h0000;
   localparam int VAL_W = 16;
   localparam int EXP_W = 20;
   localparam int PRE_W = 8;

   typedef enum logic [2:0] {
      MTC_RATE_250 = 3'b000,
      MTC_RATE_500 = 3'b001,
      MTC_RATE_1K = 3'b010,
      MTC_RATE_2K = 3'b011,
      MTC_RATE_4K = 3'b100
   } mtc_rate_t;
   localparam mtc_rate_t RATE_RESET = MTC_RATE_2K;

   typedef enum logic [2:0] {
      MTC_TRG_OFF = 3'b000,
      MTC_TRG_LVL_HI = 3'b001,
      MTC_TRG_LVL_LO = 3'b010,
      MTC_TRG_RISE = 3'b011,
      MTC_TRG_FALL = 3'b100,
      MTC_TRG_CMD = 3'b101
   } mtc_trig_t;

   typedef enum logic [1:0] {
      MTC_FN_OFF = 2'b00,
      MTC_FN_TRIG = 2'b01,
      MTC_FN_ZERO = 2'b10,
      MTC_FN_TEACH = 2'b11
   } mtc_fn_t;

   typedef enum logic [1:0] {
      MTC_TASK_STD = 2'b00,
      MTC_TASK_MULTI = 2'b01,
      MTC_TASK_PENET = 2'b10
   } mtc_task_t;

   // Measuring cycle length in clocks for a rate
   function automatic logic [21:0] mtc_cycle_clks(input mtc_rate_t r);
      case (r)
         MTC_RATE_250: mtc_cycle_clks = 22'(CYC_4K_CLKS * 16);
         MTC_RATE_500: mtc_cycle_clks = 22'(CYC_4K_CLKS * 8);
         MTC_RATE_1K: mtc_cycle_clks = 22'(CYC_4K_CLKS * 4);
         MTC_RATE_2K: mtc_cycle_clks = 22'(CYC_4K_CLKS * 2);
         default: mtc_cycle_clks = 22'(CYC_4K_CLKS);
      endcase
   endfunction : mtc_cycle_clks

   // Exposure limit in clocks: whole cycle less a readout margin
   function automatic logic [EXP_W-1:0] mtc_exp_max(input mtc_rate_t r);
      logic [21:0] c;
      c = mtc_cycle_clks(r);
      mtc_exp_max = EXP_W'(c - 22'(CYC_4K_CLKS / 5));
   endfunction : mtc_exp_max
endpackage : mtc_pkg

// ---- mtc_sensor.sv ----
// Sensor end: measuring cycle timebase, trigger qualification, output gating.
// Assumes raw samples arrive once per cycle on i_raw; trigger pin is async.
`timescale 1ns/1ps
module mtc_sensor
   import mtc_pkg::*;
#(
   // Divides every cycle and pulse count; 1 gives the real timing
   parameter int TIME_DIV = 1
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   mtc_if.sensor lnk,
   input wire mtc_rate_t i_rate,
   input wire logic i_rate_wr,
   input wire logic i_factory,
   input wire logic i_save,
   input wire mtc_fn_t i_din_fn,
   input wire mtc_fn_t i_key_fn,
   input wire logic i_key,
   input wire logic [VAL_W-1:0] i_master,
   input wire logic [VAL_W-1:0] i_raw,
   input wire logic i_laser_set,
   input wire logic i_laser_en_n,
   input wire mtc_task_t i_task,
   output logic o_laser_on,
   output logic o_cycle,
   output logic [EXP_W-1:0] o_exp_max,
   output logic [PRE_W-1:0] o_preset,
   output logic o_teach,
   output mtc_rate_t o_rate
);
   ////////////////////////////////////////////////////////////////
   mtc_rate_t rate_r, saved_r;
   logic [21:0] cyc_cnt_r;
   logic tick;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         saved_r <= RATE_RESET;
      end else if (i_factory) begin
         saved_r <= RATE_RESET;
      end else if (i_save) begin
         saved_r <= rate_r;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rate_r <= RATE_RESET;
      end else if (i_factory) begin
         rate_r <= RATE_RESET;
      end else if (i_rate_wr && i_rate <= MTC_RATE_4K) begin
         rate_r <= i_rate;
      end
   end

   assign tick = (cyc_cnt_r == 22'h0);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cyc_cnt_r <= 22'h0;
      end else if (tick) begin
         cyc_cnt_r <= 22'(mtc_cycle_clks(rate_r) / TIME_DIV) - 22'h1;
      end else begin
         cyc_cnt_r <= cyc_cnt_r - 22'h1;
      end
   end
   assign o_cycle = tick;
   assign o_rate = rate_r;
   assign o_exp_max = mtc_exp_max(rate_r);

   ////////////////////////////////////////////////////////////////
   // Trigger pin synchroniser and 50 us qualifier
   logic pin_s1_r, pin_s2_r, pin_q_r, pin_q_d_r;
   logic [13:0] flt_cnt_r;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
      end else begin
         pin_s1_r <= lnk.trig_pin;
         pin_s2_r <= pin_s1_r;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         flt_cnt_r <= 14'h0;
         pin_q_r <= 1'b0;
      end else if (pin_s2_r == pin_q_r) begin
         flt_cnt_r <= 14'h0;
      end else if (flt_cnt_r == 14'(TRIG_MIN_CLKS / TIME_DIV - 1)) begin
         flt_cnt_r <= 14'h0;
         pin_q_r <= pin_s2_r;
      end else begin
         flt_cnt_r <= flt_cnt_r + 14'h1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) pin_q_d_r <= 1'b0;
      else pin_q_d_r <= pin_q_r;
   end

   logic din_trig;
   assign din_trig = (i_din_fn == MTC_FN_TRIG);
   logic rise, fall, lvl_act, edge_ev;
   assign rise = pin_q_r & ~pin_q_d_r;
   assign fall = ~pin_q_r & pin_q_d_r;
   always_comb begin
      lvl_act = 1'b0;
      edge_ev = 1'b0;
      case (lnk.cfg_mode)
         MTC_TRG_LVL_HI: lvl_act = din_trig & pin_q_r;
         MTC_TRG_LVL_LO: lvl_act = din_trig & ~pin_q_r;
         MTC_TRG_RISE: edge_ev = din_trig & rise;
         MTC_TRG_FALL: edge_ev = din_trig & fall;
         MTC_TRG_CMD: edge_ev = lnk.cmd_trig;
         default: begin
            lvl_act = 1'b0;
            edge_ev = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Per-cycle trigger sampling, burst counter
   logic ev_pend_r, lvl_seen_r;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) ev_pend_r <= 1'b0;
      else if (edge_ev) ev_pend_r <= 1'b1; // set wins over clear
      else if (tick) ev_pend_r <= 1'b0;
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) lvl_seen_r <= 1'b0;
      else if (tick) lvl_seen_r <= lvl_act;
      else if (lvl_act) lvl_seen_r <= 1'b1;
   end

   logic [13:0] burst_r;
   logic burst_act;
   assign burst_act = (burst_r != CNT_STOP);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         burst_r <= CNT_STOP;
      end else if (lnk.cmd_stop) begin
         burst_r <= CNT_STOP;
      end else if (tick && ev_pend_r) begin
         // Trigger cycle itself is the first value; the counter holds the rest
         if (lnk.cfg_count == CNT_ENDLESS || lnk.cfg_count == CNT_STOP) begin
            burst_r <= lnk.cfg_count;
         end else begin
            burst_r <= lnk.cfg_count - 14'h1;
         end
      end else if (tick && burst_act && burst_r != CNT_ENDLESS) begin
         burst_r <= burst_r - 14'h1;
      end
   end

   logic enable_cyc;
   always_comb begin
      case (lnk.cfg_mode)
         MTC_TRG_OFF: enable_cyc = 1'b1;
         MTC_TRG_LVL_HI, MTC_TRG_LVL_LO: enable_cyc = lvl_seen_r;
         default: enable_cyc = (ev_pend_r && lnk.cfg_count != CNT_STOP) || burst_act;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Three-cycle pipeline; gate at acquisition, also with cfg_out_trig set
   logic [VAL_W-1:0] pipe_r [PIPE_CYCLES];
   logic [PIPE_CYCLES-1:0] pv_r;
   logic [PIPE_CYCLES-1:0] en_r;
   logic [VAL_W-1:0] offs_r;
   logic zero_req;
   assign zero_req = (i_din_fn == MTC_FN_ZERO && pin_q_r && !pin_q_d_r)
      || (i_key_fn == MTC_FN_ZERO && i_key);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) offs_r <= '0;
      else if (zero_req) offs_r <= i_raw - i_master;
   end
   assign o_teach = (i_din_fn == MTC_FN_TEACH && rise)
      || (i_key_fn == MTC_FN_TEACH && i_key);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pv_r <= '0;
         en_r <= '0;
      end else if (tick) begin
         // Acquisition gate: only triggered cycles enter; output gate: all do when cfg_out_trig is set
         pv_r <= {pv_r[PIPE_CYCLES-2:0], lnk.cfg_out_trig | enable_cyc};
         en_r <= {en_r[PIPE_CYCLES-2:0], enable_cyc};
      end
   end

   genvar g;
   generate
      for (g = 0; g < PIPE_CYCLES; g++) begin : g_pipe
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) pipe_r[g] <= '0;
            else if (tick) pipe_r[g] <= (g == 0) ? i_raw - offs_r : pipe_r[g == 0 ? 0 : g-1];
         end
      end
   endgenerate

   logic fire;
   assign fire = tick && pv_r[PIPE_CYCLES-1] && en_r[PIPE_CYCLES-1];
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         lnk.val_valid <= 1'b0;
         lnk.val_data <= '0;
      end else begin
         lnk.val_valid <= fire;
         if (fire) lnk.val_data <= pipe_r[PIPE_CYCLES-1];
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) lnk.analog <= '0;
      else if (fire) lnk.analog <= pipe_r[PIPE_CYCLES-1];
   end

   ////////////////////////////////////////////////////////////////
   // Laser enable pin synchroniser, idles at not grounded
   logic laser_s1_r, laser_s2_r;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         laser_s1_r <= 1'b1;
         laser_s2_r <= 1'b1;
      end else begin
         laser_s1_r <= i_laser_en_n;
         laser_s2_r <= laser_s1_r;
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) o_laser_on <= 1'b0;
      else o_laser_on <= i_laser_set & ~laser_s2_r;
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_preset <= 8'h00;
      end else begin
         case (i_task)
            MTC_TASK_STD: o_preset <= 8'h01;
            MTC_TASK_MULTI: o_preset <= 8'h02;
            MTC_TASK_PENET: o_preset <= 8'h04;
            default: o_preset <= 8'h01;
         endcase
      end
   end
endmodule : mtc_sensor
